// File: pkg/fpc_pkg.sv
package fpc_pkg;

   // Byte addresses on the register port
   localparam logic [7:0] ADDR_CMD_INDEX   = 8'h02;
   localparam logic [7:0] ADDR_STATUS      = 8'h06;
   localparam logic [7:0] ADDR_PFLASH_PROT = 8'h08;
   localparam logic [7:0] ADDR_EEPROM_PROT = 8'h09;
   localparam logic [7:0] ADDR_OPTION      = 8'h0A;
   localparam logic [7:0] ADDR_FACTORY_RSV = 8'h0B;
   localparam logic [7:0] ADDR_CCOB_FIRST  = 8'h0C;
   localparam logic [7:0] ADDR_CCOB_LAST   = 8'h17;
   localparam int         CCOB_WORDS       = 6;

   // Status register bit positions
   localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
   localparam int STAT_VIOL_BIT = 5;

   // Program-flash protection field positions
   localparam int PF_OPEN_BIT   = 7;
   localparam int PF_RSV_BIT    = 6;
   localparam int PF_HDIS_BIT   = 5;
   localparam int PF_HS_LSB     = 3;
   localparam int PF_LDIS_BIT   = 2;
   localparam int PF_LS_LSB     = 0;

   // EEPROM protection field positions
   localparam int EE_OPEN_BIT   = 7;
   localparam int EE_SIZE_LSB   = 0;

   // Fully protected values used before load and on double-bit fault
   localparam logic [7:0] PF_PROT_SAFE = 8'h7F;
   localparam logic [7:0] EE_PROT_SAFE = 8'h03;
   localparam logic [7:0] OPTION_SAFE  = 8'hFF;
   localparam logic [7:0] EE_PROT_MASK = 8'h83;

   // Row = present scenario, bit = permitted next scenario
   localparam logic [7:0][7:0] PF_ALLOWED = {8'hFF, 8'h5A, 8'h3C, 8'h18,
                                             8'h08, 8'h0C, 8'h0A, 8'h0F};

   // EEPROM address window
   localparam logic [23:0] EE_BASE = 24'h10_0000;
   localparam logic [23:0] EE_SPAN = 24'h00_1000;

   // Command codes checked against EEPROM protection
   localparam logic [7:0] CMD_ERASE_BLOCK  = 8'h09;
   localparam logic [7:0] CMD_EE_PROGRAM   = 8'h20;
   localparam logic [7:0] CMD_EE_ERASE_SEC = 8'h21;

   typedef logic [CCOB_WORDS-1:0][15:0] fpc_words_t;

   typedef struct packed {
      logic [7:0] pflash_prot;
      logic [7:0] eeprom_prot;
      logic [7:0] option;
      logic       pflash_fault;
      logic       eeprom_fault;
      logic       option_fault;
   } fpc_cfg_s;

   typedef struct packed {
      fpc_words_t words;
      logic [2:0] word_index;
   } fpc_cmd_s;

   typedef enum logic {
      FPC_LOADING = 1'b0,
      FPC_RUN     = 1'b1
   } fpc_state_e;

endpackage

// File: hdl/fpc_regs.sv
// Functional notes
// - Normal mode ignores program-flash protection writes to a scenario not permitted.
// - Permitted scenario moves follow the fixed from/to table, scenario 7 reaches all.
// - Program-flash protection register reads back the scenario actually in force.
// - Normal mode EEPROM protection writes must grow size; open bit only 1 to 0.
// - EEPROM open bit 7 set disables protection; clear protects the size range.
// - Special mode writes EEPROM open bit and size freely.
// - EEPROM protection loaded from configuration byte during reset sequence.
// - Program or erase hitting protected EEPROM is refused and sets violation flag.
// - Whole EEPROM block erase refused while any EEPROM sector is protected.
// - Size field 00..11 protects 32, 64, 96 or 128 bytes from base.
// - Option register readable in all bits, writes have no effect.
// - Option register loaded with all eight bits from configuration byte at reset.
// - Double-bit fault on option phrase sets every option bit.
// - Factory reserved register reads zero, ignores writes.
// - Command object array is six 16-bit words, byte readable and writable.
// - Writing 1 to completion flag clears it and hands array to controller.
// - Array locked while flag clear; flag set again when command finishes.
// - Command results land in the array, valid once flag is back to 1.
// - Word 0 is code and address high byte, word 1 address low, 2..5 data.
// - Range size fields writable only while their range disable bit is set.
`timescale 1ns/10ps
module fpc_regs (
   input  wire logic                 ref_clk_in,
   input  wire logic                 srst_in,
   input  wire logic                 special_mode_in,
   input  wire logic [7:0]           addr_in,
   input  wire logic [7:0]           wr_data_in,
   input  wire logic                 wr_en_in,
   input  wire logic                 rd_en_in,
   output logic [7:0]                rd_data_out,
   input  wire fpc_pkg::fpc_cfg_s    cfg_in,
   input  wire logic                 cfg_valid_in,
   output fpc_pkg::fpc_cmd_s         cmd_out,
   output logic                      cmd_launch_out,
   input  wire logic                 cmd_done_in,
   input  wire fpc_pkg::fpc_words_t  result_in,
   input  wire logic [5:0]           result_we_in,
   output logic                      command_complete_flag_out,
   output logic                      viol_out,
   output logic [7:0]                pflash_prot_out,
   output logic [7:0]                eeprom_prot_out,
   output logic [7:0]                option_out,
   output logic                      loaded_out
);

   fpc_pkg::fpc_state_e  state_ff;
   fpc_pkg::fpc_state_e  nxt_state;
   fpc_pkg::fpc_words_t  ccob_ff;
   fpc_pkg::fpc_words_t  nxt_ccob;
   fpc_pkg::fpc_cmd_s    cmd_ff;
   fpc_pkg::fpc_cmd_s    nxt_cmd;
   logic [2:0]           index_ff;
   logic [2:0]           nxt_index;
   logic [7:0]           pf_ff;
   logic [7:0]           nxt_pf;
   logic [7:0]           ee_ff;
   logic [7:0]           nxt_ee;
   logic [7:0]           opt_ff;
   logic [7:0]           nxt_opt;
   logic                 command_complete_flag_ff;
   logic                 nxt_command_complete_flag;
   logic                 viol_ff;
   logic                 nxt_viol;
   logic                 launch_ff;
   logic                 nxt_launch;
   logic [7:0]           rd_ff;
   logic [7:0]           nxt_rd;

   function automatic logic is_ccob(input logic [7:0] a);
      is_ccob = (a >= fpc_pkg::ADDR_CCOB_FIRST) && (a <= fpc_pkg::ADDR_CCOB_LAST);
   endfunction

   function automatic logic [2:0] ccob_word(input logic [7:0] a);
      logic [7:0] off;
      off = a - fpc_pkg::ADDR_CCOB_FIRST;
      ccob_word = off[3:1];
   endfunction

   function automatic logic [2:0] scenario(input logic [7:0] p);
      scenario = {p[fpc_pkg::PF_OPEN_BIT], p[fpc_pkg::PF_HDIS_BIT],
                  p[fpc_pkg::PF_LDIS_BIT]};
   endfunction

   // EEPROM protection check of a pending command
   function automatic logic ee_refused(input logic [7:0] prot,
                                       input fpc_pkg::fpc_words_t w);
      logic [23:0] addr;
      logic [23:0] off;
      logic        in_ee;
      logic        open;
      addr  = {w[0][7:0], w[1]};
      off   = addr - fpc_pkg::EE_BASE;
      in_ee = (addr >= fpc_pkg::EE_BASE) && (off < fpc_pkg::EE_SPAN);
      open  = prot[fpc_pkg::EE_OPEN_BIT];
      ee_refused = 1'b0;
      if (in_ee && !open)
      begin
         if (w[0][15:8] == fpc_pkg::CMD_EE_PROGRAM ||
             w[0][15:8] == fpc_pkg::CMD_EE_ERASE_SEC)
         begin
            // Region is (size+1) * 32 bytes from base
            ee_refused = (off[23:7] == 17'h0_0000) &&
                         (off[6:5] <= prot[fpc_pkg::EE_SIZE_LSB +: 2]);
         end
         else if (w[0][15:8] == fpc_pkg::CMD_ERASE_BLOCK)
         begin
            // Open clear always protects at least one sector
            ee_refused = 1'b1;
         end
      end
   endfunction

   // Program-flash protection write filter
   function automatic logic [7:0] pf_write(input logic [7:0] cur,
                                           input logic [7:0] req,
                                           input logic       special);
      logic [7:0] res;
      res = cur;
      if (special || fpc_pkg::PF_ALLOWED[scenario(cur)][scenario(req)])
      begin
         res[fpc_pkg::PF_OPEN_BIT] = req[fpc_pkg::PF_OPEN_BIT];
         res[fpc_pkg::PF_HDIS_BIT] = req[fpc_pkg::PF_HDIS_BIT];
         res[fpc_pkg::PF_LDIS_BIT] = req[fpc_pkg::PF_LDIS_BIT];
         if (cur[fpc_pkg::PF_HDIS_BIT])
         begin
            res[fpc_pkg::PF_HS_LSB +: 2] = req[fpc_pkg::PF_HS_LSB +: 2];
         end
         if (cur[fpc_pkg::PF_LDIS_BIT])
         begin
            res[fpc_pkg::PF_LS_LSB +: 2] = req[fpc_pkg::PF_LS_LSB +: 2];
         end
      end
      pf_write = res;
   endfunction

   // EEPROM protection write filter
   function automatic logic [7:0] ee_write(input logic [7:0] cur,
                                           input logic [7:0] req,
                                           input logic       special);
      logic       c_open;
      logic       r_open;
      logic [1:0] c_size;
      logic [1:0] r_size;
      logic       take;
      c_open = cur[fpc_pkg::EE_OPEN_BIT];
      r_open = req[fpc_pkg::EE_OPEN_BIT];
      c_size = cur[fpc_pkg::EE_SIZE_LSB +: 2];
      r_size = req[fpc_pkg::EE_SIZE_LSB +: 2];
      if (special)
      begin
         take = 1'b1;
      end
      else if (c_open)
      begin
         // Size is irrelevant while open, so any open-to-closed or stay-open write is growth
         take = 1'b1;
      end
      else
      begin
         take = !r_open && (r_size > c_size);
      end
      ee_write = take ? (req & fpc_pkg::EE_PROT_MASK) : cur;
   endfunction

   // Protection group: load state, program-flash, EEPROM and option bytes
   always_comb
   begin
      nxt_state  = state_ff;
      nxt_pf     = pf_ff;
      nxt_ee     = ee_ff;
      nxt_opt    = opt_ff;

      unique case (state_ff)
         fpc_pkg::FPC_LOADING:
         begin
            // Bus writes are dropped until the configuration bytes are in
            if (cfg_valid_in)
            begin
               nxt_pf  = cfg_in.pflash_fault ? fpc_pkg::PF_PROT_SAFE : cfg_in.pflash_prot;
               nxt_ee  = cfg_in.eeprom_fault ? fpc_pkg::EE_PROT_SAFE :
                         (cfg_in.eeprom_prot & fpc_pkg::EE_PROT_MASK);
               nxt_opt = cfg_in.option_fault ? fpc_pkg::OPTION_SAFE :
                         cfg_in.option;
               nxt_state = fpc_pkg::FPC_RUN;
            end
         end
         fpc_pkg::FPC_RUN:
         begin
            if (wr_en_in)
            begin
               if (addr_in == fpc_pkg::ADDR_PFLASH_PROT)
               begin
                  nxt_pf = pf_write(pf_ff, wr_data_in, special_mode_in);
               end
               else if (addr_in == fpc_pkg::ADDR_EEPROM_PROT)
               begin
                  nxt_ee = ee_write(ee_ff, wr_data_in, special_mode_in);
               end
               // Option and factory registers ignore writes
            end
         end
      endcase
   end

   // Command group: array, index, flags and the hand-over to the controller
   always_comb
   begin
      nxt_ccob   = ccob_ff;
      nxt_cmd    = cmd_ff;
      nxt_index  = index_ff;
      nxt_command_complete_flag   = command_complete_flag_ff;
      nxt_viol   = viol_ff;
      nxt_launch = 1'b0;

      unique case (state_ff)
         fpc_pkg::FPC_LOADING:
         begin
            // Array, index and status writes wait for the load as well
         end
         fpc_pkg::FPC_RUN:
         begin
            if (wr_en_in)
            begin
               if (addr_in == fpc_pkg::ADDR_CMD_INDEX && command_complete_flag_ff)
               begin
                  nxt_index = wr_data_in[2:0];
               end
               else if (is_ccob(addr_in) && command_complete_flag_ff)
               begin
                  if (addr_in[0])
                  begin
                     nxt_ccob[ccob_word(addr_in)][7:0] = wr_data_in;
                  end
                  else
                  begin
                     nxt_ccob[ccob_word(addr_in)][15:8] = wr_data_in;
                  end
               end
               else if (addr_in == fpc_pkg::ADDR_STATUS)
               begin
                  if (wr_data_in[fpc_pkg::STAT_VIOL_BIT])
                  begin
                     nxt_viol = 1'b0;
                  end
                  if (wr_data_in[fpc_pkg::STAT_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag_ff)
                  begin
                     if (ee_refused(ee_ff, ccob_ff))
                     begin
                        // Refused command never reaches the controller
                        nxt_viol = 1'b1;
                     end
                     else
                     begin
                        nxt_command_complete_flag   = 1'b0;
                        nxt_launch = 1'b1;
                        nxt_cmd.words      = ccob_ff;
                        nxt_cmd.word_index = index_ff;
                     end
                  end
               end
            end
            if (cmd_done_in && !command_complete_flag_ff)
            begin
               nxt_command_complete_flag = 1'b1;
               for (int i = 0; i < fpc_pkg::CCOB_WORDS; i++)
               begin
                  if (result_we_in[i])
                  begin
                     nxt_ccob[i] = result_in[i];
                  end
               end
            end
         end
      endcase
   end

   // Read group: data stand one cycle only, then fall back to zero
   always_comb
   begin
      nxt_rd = 8'h00;
      if (rd_en_in)
      begin
         if (addr_in == fpc_pkg::ADDR_PFLASH_PROT)
         begin
            nxt_rd = pf_ff;
         end
         else if (addr_in == fpc_pkg::ADDR_EEPROM_PROT)
         begin
            nxt_rd = ee_ff;
         end
         else if (addr_in == fpc_pkg::ADDR_OPTION)
         begin
            nxt_rd = opt_ff;
         end
         else if (addr_in == fpc_pkg::ADDR_FACTORY_RSV)
         begin
            nxt_rd = 8'h00;
         end
         else if (addr_in == fpc_pkg::ADDR_CMD_INDEX)
         begin
            nxt_rd = {5'h00, index_ff};
         end
         else if (addr_in == fpc_pkg::ADDR_STATUS)
         begin
            nxt_rd[fpc_pkg::STAT_COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag_ff;
            nxt_rd[fpc_pkg::STAT_VIOL_BIT] = viol_ff;
         end
         else if (is_ccob(addr_in))
         begin
            nxt_rd = addr_in[0] ? ccob_ff[ccob_word(addr_in)][7:0] :
                                  ccob_ff[ccob_word(addr_in)][15:8];
         end
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         state_ff  <= fpc_pkg::FPC_LOADING;
         pf_ff     <= fpc_pkg::PF_PROT_SAFE;
         ee_ff     <= fpc_pkg::EE_PROT_SAFE;
         opt_ff    <= fpc_pkg::OPTION_SAFE;
      end
      else
      begin
         state_ff  <= nxt_state;
         pf_ff     <= nxt_pf;
         ee_ff     <= nxt_ee;
         opt_ff    <= nxt_opt;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         ccob_ff   <= '0;
         cmd_ff    <= '0;
         index_ff  <= 3'h0;
         command_complete_flag_ff   <= 1'b1;
         viol_ff   <= 1'b0;
         launch_ff <= 1'b0;
      end
      else
      begin
         ccob_ff   <= nxt_ccob;
         cmd_ff    <= nxt_cmd;
         index_ff  <= nxt_index;
         command_complete_flag_ff   <= nxt_command_complete_flag;
         viol_ff   <= nxt_viol;
         launch_ff <= nxt_launch;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         rd_ff     <= 8'h00;
      end
      else
      begin
         rd_ff     <= nxt_rd;
      end
   end

   assign rd_data_out     = rd_ff;
   assign cmd_out         = cmd_ff;
   assign cmd_launch_out  = launch_ff;
   assign command_complete_flag_out        = command_complete_flag_ff;
   assign viol_out        = viol_ff;
   assign pflash_prot_out = pf_ff;
   assign eeprom_prot_out = ee_ff;
   assign option_out      = opt_ff;
   assign loaded_out      = state_ff;

endmodule

// File: verif/fpc_regs_assertions.sv
`timescale 1ns/10ps
module fpc_regs_assertions (
   input  wire logic              ref_clk_in,
   input  wire logic              srst_in,
   input  wire logic              special_mode_in,
   input  wire logic [7:0]        addr_in,
   input  wire logic [7:0]        wr_data_in,
   input  wire logic              wr_en_in,
   input  wire logic              rd_en_in,
   input  wire logic [7:0]        rd_data_out,
   input  wire fpc_pkg::fpc_cmd_s cmd_out,
   input  wire logic              cmd_launch_out,
   input  wire logic              cmd_done_in,
   input  wire logic              command_complete_flag_out,
   input  wire logic              viol_out,
   input  wire logic [7:0]        pflash_prot_out,
   input  wire logic [7:0]        eeprom_prot_out,
   input  wire logic [7:0]        option_out,
   input  wire logic              loaded_out
);
   logic [2:0] scen;
   assign scen = {pflash_prot_out[7], pflash_prot_out[5], pflash_prot_out[2]};

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   sequence launch_req;
      wr_en_in && addr_in == fpc_pkg::ADDR_STATUS && wr_data_in[7] && command_complete_flag_out && loaded_out;
   endsequence
   sequence launch_ack;
      (cmd_launch_out && !command_complete_flag_out) || (viol_out && command_complete_flag_out);
   endsequence

   // Load edge excluded: the loaded value may be any scenario
   pf_filter_a: assert property (loaded_out && $past(loaded_out) && !$past(special_mode_in)
      |-> fpc_pkg::PF_ALLOWED[$past(scen)][scen]) else $error("pflash scenario move not allowed");
   pf_read_a: assert property (rd_en_in && addr_in == fpc_pkg::ADDR_PFLASH_PROT
      |=> rd_data_out == $past(pflash_prot_out)) else $error("pflash read not in force value");
   opt_read_a: assert property (rd_en_in && addr_in == fpc_pkg::ADDR_OPTION
      |=> rd_data_out == $past(option_out)) else $error("option read wrong");
   opt_fixed_a: assert property (loaded_out && $past(loaded_out) |-> $stable(option_out))
      else $error("option changed after load");
   rsv_zero_a: assert property (rd_en_in && addr_in == fpc_pkg::ADDR_FACTORY_RSV
      |=> rd_data_out == 8'h00) else $error("reserved read not zero");
   ee_write_a: assert property (loaded_out && $past(loaded_out) && $changed(eeprom_prot_out)
      |-> $past(wr_en_in) && $past(addr_in) == fpc_pkg::ADDR_EEPROM_PROT)
      else $error("eeprom protection changed without write");
   launch_ack_a: assert property (launch_req |=> launch_ack)
      else $error("launch not answered");
   launch_pulse_a: assert property (cmd_launch_out |=> !cmd_launch_out)
      else $error("launch longer than one cycle");
   flag_low_a: assert property (!command_complete_flag_out && !cmd_done_in |=> !command_complete_flag_out)
      else $error("flag set without done");
   flag_done_a: assert property (!command_complete_flag_out && cmd_done_in |=> command_complete_flag_out)
      else $error("flag not set on done");
   cmd_hold_a: assert property (!cmd_launch_out |-> $stable(cmd_out))
      else $error("command changed without launch");
endmodule

bind fpc_regs fpc_regs_assertions chk_u (.ref_clk_in, .srst_in, .special_mode_in, .addr_in,
   .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .cmd_out, .cmd_launch_out, .cmd_done_in,
   .command_complete_flag_out, .viol_out, .pflash_prot_out, .eeprom_prot_out, .option_out, .loaded_out);

// File: verif/fpc_regs_bench.sv
`timescale 1ns/10ps
module fpc_regs_bench;
   logic                ref_clk_in;
   logic                srst_in;
   logic                special_mode_in;
   logic [7:0]          addr_in;
   logic [7:0]          wr_data_in;
   logic                wr_en_in;
   logic                rd_en_in;
   logic [7:0]          rd_data_out;
   fpc_pkg::fpc_cfg_s   cfg_in;
   logic                cfg_valid_in;
   fpc_pkg::fpc_cmd_s   cmd_out;
   logic                cmd_launch_out;
   logic                cmd_done_in;
   fpc_pkg::fpc_words_t result_in;
   logic [5:0]          result_we_in;
   logic                command_complete_flag_out;
   logic                viol_out;
   logic [7:0]          pflash_prot_out;
   logic [7:0]          eeprom_prot_out;
   logic [7:0]          option_out;
   logic                loaded_out;
   int                  err_total;
   int                  tests_run;
   localparam logic [0:5][2:0] PF_TRY = {3'd5, 3'd6, 3'd4, 3'd7, 3'd3, 3'd0};
   localparam logic [0:5][2:0] PF_EXP = {3'd5, 3'd5, 3'd4, 3'd4, 3'd3, 3'd3};
   localparam logic [7:0]      EE     = fpc_pkg::ADDR_EEPROM_PROT;
   localparam logic [7:0]      ST     = fpc_pkg::ADDR_STATUS;

   fpc_regs dut_u (.ref_clk_in, .srst_in, .special_mode_in, .addr_in, .wr_data_in, .wr_en_in,
      .rd_en_in, .rd_data_out, .cfg_in, .cfg_valid_in, .cmd_out, .cmd_launch_out, .cmd_done_in,
      .result_in, .result_we_in, .command_complete_flag_out, .viol_out, .pflash_prot_out, .eeprom_prot_out,
      .option_out, .loaded_out);

   // Scenario code to register byte; bit 6 and size fields stay at their loaded ones
   function automatic logic [7:0] pf(input logic [2:0] s);
      return {s[2], 1'b1, s[1], 2'b11, s[0], 2'b11};
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_en_in   <= 1'b1;
      @(posedge ref_clk_in);
      wr_en_in   <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_en_in <= 1'b0;
      @(negedge ref_clk_in);
      chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, rd_data_out});
   endtask

   // Returns in the cycle after the launch write, where the answer stands
   task automatic launch(input logic [7:0] code, input logic [23:0] adr);
      wr(8'h0C, code);
      wr(8'h0D, adr[23:16]);
      wr(8'h0E, adr[15:8]);
      wr(8'h0F, adr[7:0]);
      wr(fpc_pkg::ADDR_CMD_INDEX, 8'h01);
      wr(ST, 8'h80);
      @(negedge ref_clk_in);
   endtask

   task automatic flags(input logic c, input logic v);
      chk("command_complete_flag", {15'h0, c}, {15'h0, command_complete_flag_out});
      chk("viol", {15'h0, v}, {15'h0, viol_out});
   endtask

   task automatic finish_cmd;
      @(posedge ref_clk_in);
      cmd_done_in <= 1'b1;
      @(posedge ref_clk_in);
      cmd_done_in <= 1'b0;
   endtask

   task automatic boot(input logic [7:0] ee_byte, input logic [2:0] flt);
      srst_in <= 1'b1;
      cfg_in  <= {8'hFF, ee_byte, 8'hA5, flt};
      repeat (10) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      @(posedge ref_clk_in);
      cfg_valid_in <= 1'b1;
      @(posedge ref_clk_in);
      cfg_valid_in <= 1'b0;
   endtask

   task automatic give_verdict;
      if (err_total == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // Under two hundred cycles are expected; far beyond means a hang
   initial
   begin
      repeat (5000) @(posedge ref_clk_in);
      err_total++;
      give_verdict();
   end

   initial
   begin
      err_total = 0;
      tests_run = 0;
      srst_in = 1'b1;
      special_mode_in = 1'b0;
      addr_in = 8'h00;
      wr_data_in = 8'h00;
      wr_en_in = 1'b0;
      rd_en_in = 1'b0;
      cfg_in = '0;
      cfg_valid_in = 1'b0;
      cmd_done_in = 1'b0;
      result_in = '0;
      result_we_in = 6'h00;
      boot(8'h80, 3'b000);
      rd(fpc_pkg::ADDR_OPTION, 8'hA5);
      wr(fpc_pkg::ADDR_OPTION, 8'h00);
      rd(fpc_pkg::ADDR_OPTION, 8'hA5);
      wr(fpc_pkg::ADDR_FACTORY_RSV, 8'hFF);
      rd(fpc_pkg::ADDR_FACTORY_RSV, 8'h00);
      rd(8'h30, 8'h00);
      rd(EE, 8'h80);
      launch(fpc_pkg::CMD_EE_PROGRAM, 24'h10_0080);
      flags(1'b0, 1'b0);
      chk("launch", 16'h0001, {15'h0, cmd_launch_out});
      chk("word0", 16'h2010, cmd_out.words[0]);
      chk("word1", 16'h0080, cmd_out.words[1]);
      chk("index", 16'h0001, {13'h0, cmd_out.word_index});
      wr(8'h0C, 8'h55);
      result_in[2] <= 16'hBEEF;
      result_we_in <= 6'h04;
      finish_cmd();
      result_we_in <= 6'h00;
      rd(8'h0C, 8'h20);
      rd(8'h10, 8'hBE);
      rd(8'h11, 8'hEF);
      rd(ST, 8'h80);
      wr(EE, 8'h01);
      rd(EE, 8'h01);
      wr(EE, 8'h00);
      rd(EE, 8'h01);
      wr(EE, 8'h80);
      rd(EE, 8'h01);
      wr(EE, 8'h03);
      rd(EE, 8'h03);
      launch(fpc_pkg::CMD_EE_PROGRAM, 24'h10_007F);
      flags(1'b1, 1'b1);
      wr(ST, 8'h20);
      launch(fpc_pkg::CMD_EE_ERASE_SEC, 24'h10_0080);
      flags(1'b0, 1'b0);
      finish_cmd();
      launch(fpc_pkg::CMD_ERASE_BLOCK, 24'h10_0000);
      flags(1'b1, 1'b1);
      wr(ST, 8'h20);
      special_mode_in <= 1'b1;
      wr(EE, 8'h80);
      rd(EE, 8'h80);
      @(posedge ref_clk_in);
      special_mode_in <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         wr(fpc_pkg::ADDR_PFLASH_PROT, pf(PF_TRY[i]));
         rd(fpc_pkg::ADDR_PFLASH_PROT, pf(PF_EXP[i]));
      end
      // Special mode lifts the scenario filter; sizes still need their disable bit
      @(posedge ref_clk_in);
      special_mode_in <= 1'b1;
      wr(fpc_pkg::ADDR_PFLASH_PROT, 8'hFF);
      rd(fpc_pkg::ADDR_PFLASH_PROT, 8'hFF);
      @(posedge ref_clk_in);
      special_mode_in <= 1'b0;
      wr(fpc_pkg::ADDR_PFLASH_PROT, 8'hC4);
      rd(fpc_pkg::ADDR_PFLASH_PROT, 8'hC4);
      wr(fpc_pkg::ADDR_PFLASH_PROT, 8'hDF);
      rd(fpc_pkg::ADDR_PFLASH_PROT, 8'hC7);
      // Second reset in mid-run, all configuration reads faulty
      @(posedge ref_clk_in);
      boot(8'h80, 3'b111);
      rd(EE, 8'h03);
      rd(fpc_pkg::ADDR_OPTION, 8'hFF);
      chk("loaded", 16'h0001, {15'h0, loaded_out});
      chk("ee_out", 16'h0003, {8'h00, eeprom_prot_out});
      chk("opt_out", 16'h00FF, {8'h00, option_out});
      chk("pf_out", 16'h007F, {8'h00, pflash_prot_out});
      give_verdict();
   end
endmodule
